// [gpb_decode.sv]
/*
  gpb_decode: host cycle routing (prefetchable window, VGA, ISA alias
  exclusion), master abort data handling and system-error messaging.
  Assumes host and graphics-port events are synchronous to SYS_CLK_I;
  registers are reached over AHB-Lite with single word transfers.
*/
// Our own choice: the AHB-Lite register port.
// Operation
// - memory in prefetch base..limit goes to graphics port
// - limit bits 15:4 writable as A31:20, bits 3:0 read zero
// - limit compare fills low twenty address bits with ones
// - back-to-back enable reads zero; back-to-back only in fast writes
// - secondary bus reset bit reads zero, never resets the port
// - master abort: drop write data, reads return all ones
// - vga bit clear: vga cycles go primary unless in a window
// - vga bit set: memory 0A0000h-0BFFFFh goes to graphics port
// - vga bit set: io low ten bits 3B0-3BB, 3C0-3DF, aliases match
// - vga forwarding ignores windows and isa exclusion
// - isa bit clear: all io in window goes to graphics port
// - isa bit set: last 768 bytes of each 1 KB go primary
// - isa exclusion touches only io already inside the window
// - parity response clear: no system error for parity errors
// - parity response set: report parity if system error enabled
// - target abort reported only when target abort bit is set
// - all system error messages gated by global enable
`timescale 1ns/1ns
module gpb_decode (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        CYC_VALID_I,
  input  wire logic        CYC_IO_I,
  input  wire logic [31:0] CYC_ADDR_I,
  output logic             CYC_DONE_O,
  output logic             CYC_TO_GFX_O,
  input  wire logic        GFX_FAST_WRITE_I,
  output logic             GFX_BACK_TO_BACK_O,
  output logic             GFX_RESET_O,
  input  wire logic        MA_VALID_I,
  input  wire logic        MA_WRITE_I,
  input  wire logic [31:0] MA_RDATA_I,
  input  wire logic        MA_ABORT_I,
  output logic             MA_DONE_O,
  output logic      [31:0] MA_RDATA_O,
  input  wire logic        GFX_PARITY_ERR_I,
  input  wire logic        GFX_TARGET_ABORT_I,
  output logic             SERR_MSG_O,
  output logic             IRQ_O
);
  logic [15:0] plimit_r;
  logic [15:0] pbase_r;
  logic [31:0] iowin_r;
  logic [7:0]  bctrl_r;
  logic [7:0]  errcmd_r;
  logic        serr_en_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_en_r;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  idx_r;

  function automatic logic in_rng(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // bus slave: writes take zero wait states and land in the data phase, reads take one
  logic addr_ok;
  assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r     <= 8'h00;
    end else begin
      if (HREADY_I) begin
        wr_pend_r <= addr_ok && HWRITE_I;
        rd_pend_r <= addr_ok && !HWRITE_I;
        idx_r     <= HADDR_I[9:2];
      end
    end
  end

  logic wr_lim;
  logic wr_bas;
  logic wr_bc;
  logic wr_ec;
  logic wr_io;
  logic wr_cmd;
  logic wr_ien;
  logic wr_clr;
  assign wr_lim = wr_pend_r && idx_r == gpb_pkg::IDX_PLIMIT;
  assign wr_bas = wr_pend_r && idx_r == gpb_pkg::IDX_PBASE;
  assign wr_bc  = wr_pend_r && idx_r == gpb_pkg::IDX_BCTRL;
  assign wr_ec  = wr_pend_r && idx_r == gpb_pkg::IDX_ERRCMD;
  assign wr_io  = wr_pend_r && idx_r == gpb_pkg::IDX_IOWIN;
  assign wr_cmd = wr_pend_r && idx_r == gpb_pkg::IDX_CMD;
  assign wr_ien = wr_pend_r && idx_r == gpb_pkg::IDX_IRQ_EN;
  assign wr_clr = wr_pend_r && idx_r == gpb_pkg::IDX_IRQ_CLR;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      plimit_r  <= gpb_pkg::PLIMIT_RST;
      pbase_r   <= gpb_pkg::PBASE_RST;
      bctrl_r   <= gpb_pkg::BCTRL_RST;
      errcmd_r  <= 8'h00;
      iowin_r   <= 32'h00000000;
      serr_en_r <= 1'b0;
      irq_en_r  <= 4'h0;
    end else begin
      if (wr_lim)
        plimit_r <= HWDATA_I[15:0] & gpb_pkg::WIN_MASK;
      if (wr_bas)
        pbase_r <= HWDATA_I[15:0] & gpb_pkg::WIN_MASK;
      if (wr_bc)
        bctrl_r <= HWDATA_I[7:0] & gpb_pkg::BCTRL_MASK;
      if (wr_ec)
        errcmd_r <= HWDATA_I[7:0] & gpb_pkg::ERRCMD_MASK;
      if (wr_io)
        iowin_r <= HWDATA_I;
      if (wr_cmd)
        serr_en_r <= HWDATA_I[0];
      if (wr_ien)
        irq_en_r <= HWDATA_I[3:0];
    end
  end

  logic [31:0] rd_val;
  always_comb begin
    case (idx_r)
      gpb_pkg::IDX_PLIMIT:   rd_val = {16'h0000, plimit_r};
      gpb_pkg::IDX_PBASE:    rd_val = {16'h0000, pbase_r};
      gpb_pkg::IDX_BCTRL:    rd_val = {24'h000000, bctrl_r};
      gpb_pkg::IDX_ERRCMD:   rd_val = {24'h000000, errcmd_r};
      gpb_pkg::IDX_IOWIN:    rd_val = iowin_r;
      gpb_pkg::IDX_CMD:      rd_val = {31'h0, serr_en_r};
      gpb_pkg::IDX_IRQ_STAT: rd_val = {28'h0000000, irq_stat_r};
      gpb_pkg::IDX_IRQ_EN:   rd_val = {28'h0000000, irq_en_r};
      default:               rd_val = 32'h00000000;
    endcase
  end

  // data is registered, so the read answer needs one wait state
  logic rd_done_r;
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      HRDATA_O    <= 32'h00000000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      rd_done_r   <= 1'b0;
    end else begin
      rd_done_r <= 1'b0;
      if (addr_ok && !HWRITE_I)
        HREADYOUT_O <= 1'b0;
      else if (rd_pend_r && !rd_done_r) begin
        HRDATA_O    <= rd_val;
        HREADYOUT_O <= 1'b1;
        rd_done_r   <= 1'b1;
      end
    end
  end

  // routing of one host cycle per valid pulse
  logic [31:0] plim_full;
  logic [31:0] pbas_full;
  logic        mem_win;
  logic        vga_mem;
  logic        vga_io;
  logic        io_win;
  logic        isa_hit;
  logic        to_gfx;
  assign plim_full = {plimit_r[15:4], gpb_pkg::LIMIT_FILL};
  assign pbas_full = {pbase_r[15:4], 20'h00000};
  assign mem_win   = in_rng(CYC_ADDR_I, pbas_full, plim_full);
  assign vga_mem   = in_rng(CYC_ADDR_I, gpb_pkg::VGA_MEM_LO,
                            gpb_pkg::VGA_MEM_HI);
  assign vga_io    = (CYC_ADDR_I[9:0] >= gpb_pkg::VGA_IO1_LO &&
                      CYC_ADDR_I[9:0] <= gpb_pkg::VGA_IO1_HI) ||
                     (CYC_ADDR_I[9:0] >= gpb_pkg::VGA_IO2_LO &&
                      CYC_ADDR_I[9:0] <= gpb_pkg::VGA_IO2_HI);
  assign io_win    = CYC_ADDR_I[15:0] >= iowin_r[15:0] &&
                     CYC_ADDR_I[15:0] <= iowin_r[31:16];
  // low 256 of each 1 KB stay, upper 768 excluded
  assign isa_hit   = bctrl_r[gpb_pkg::BC_ISA] &&
                     CYC_ADDR_I[9:8] != 2'b00;

  always_comb begin
    if (CYC_IO_I)
      to_gfx = (bctrl_r[gpb_pkg::BC_VGA] && vga_io) ||
               (io_win && !isa_hit);
    else
      to_gfx = (bctrl_r[gpb_pkg::BC_VGA] && vga_mem) || mem_win;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      CYC_DONE_O   <= 1'b0;
      CYC_TO_GFX_O <= 1'b0;
    end else begin
      CYC_DONE_O <= CYC_VALID_I;
      if (CYC_VALID_I)
        CYC_TO_GFX_O <= to_gfx;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      GFX_BACK_TO_BACK_O <= 1'b0;
      GFX_RESET_O        <= 1'b0;
    end else begin
      GFX_BACK_TO_BACK_O <= GFX_FAST_WRITE_I;
      GFX_RESET_O        <= 1'b0;
    end
  end

  // master completion on the graphics port
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      MA_DONE_O  <= 1'b0;
      MA_RDATA_O <= 32'h00000000;
    end else begin
      MA_DONE_O <= MA_VALID_I;
      if (MA_VALID_I && !MA_WRITE_I)
        MA_RDATA_O <= MA_ABORT_I ? gpb_pkg::ALL_ONES : MA_RDATA_I;
    end
  end

  // error messaging
  logic perr_rep;
  logic ta_rep;
  logic serr_ev;
  assign perr_rep = GFX_PARITY_ERR_I &&
                    bctrl_r[gpb_pkg::BC_PER];
  assign ta_rep   = GFX_TARGET_ABORT_I &&
                    errcmd_r[gpb_pkg::EC_TAE];
  assign serr_ev  = serr_en_r && (perr_rep || ta_rep);

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      SERR_MSG_O <= 1'b0;
    else
      SERR_MSG_O <= serr_ev;
  end

  logic [3:0] ev;
  assign ev = {serr_ev, MA_VALID_I && MA_ABORT_I,
               GFX_TARGET_ABORT_I, GFX_PARITY_ERR_I};

  // a new event wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      irq_stat_r <= 4'h0;
    else
      irq_stat_r <= (irq_stat_r & ~(wr_clr ? HWDATA_I[3:0] : 4'h0)) | ev;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(((irq_stat_r & ~(wr_clr ? HWDATA_I[3:0] : 4'h0)) | ev)
                 & irq_en_r);
  end

  property p_serr_gate;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    SERR_MSG_O |-> $past(serr_en_r);
  endproperty
  a_serr_gate: assert property (p_serr_gate)
    else $error("system error without global enable");

  property p_perr_quiet;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (GFX_PARITY_ERR_I && !bctrl_r[gpb_pkg::BC_PER] && !ta_rep)
      |=> !SERR_MSG_O;
  endproperty
  a_perr_quiet: assert property (p_perr_quiet)
    else $error("parity reported while response off");

  property p_perr_rep;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (GFX_PARITY_ERR_I && bctrl_r[gpb_pkg::BC_PER] && serr_en_r)
      |=> SERR_MSG_O;
  endproperty
  a_perr_rep: assert property (p_perr_rep)
    else $error("parity error not reported");

  property p_ta_rep;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (GFX_TARGET_ABORT_I && !perr_rep) |=>
      (SERR_MSG_O == $past(errcmd_r[gpb_pkg::EC_TAE] && serr_en_r));
  endproperty
  a_ta_rep: assert property (p_ta_rep)
    else $error("target abort report mismatch");

  property p_ma_ones;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (MA_VALID_I && !MA_WRITE_I && MA_ABORT_I)
      |=> MA_DONE_O && MA_RDATA_O == gpb_pkg::ALL_ONES;
  endproperty
  a_ma_ones: assert property (p_ma_ones)
    else $error("aborted read not all ones");

  property p_vga_mem;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (CYC_VALID_I && !CYC_IO_I && vga_mem && bctrl_r[gpb_pkg::BC_VGA])
      |=> CYC_TO_GFX_O;
  endproperty
  a_vga_mem: assert property (p_vga_mem)
    else $error("vga memory not forwarded");

  property p_vga_io;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (CYC_VALID_I && CYC_IO_I && vga_io && bctrl_r[gpb_pkg::BC_VGA])
      |=> CYC_TO_GFX_O;
  endproperty
  a_vga_io: assert property (p_vga_io)
    else $error("vga io not forwarded");

  property p_isa;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (CYC_VALID_I && CYC_IO_I && isa_hit && !bctrl_r[gpb_pkg::BC_VGA])
      |=> !CYC_TO_GFX_O;
  endproperty
  a_isa: assert property (p_isa)
    else $error("isa alias forwarded");

  property p_io_win;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (CYC_VALID_I && CYC_IO_I && io_win && !bctrl_r[gpb_pkg::BC_ISA])
      |=> CYC_TO_GFX_O;
  endproperty
  a_io_win: assert property (p_io_win)
    else $error("io window cycle not forwarded");

  // 1x mode must never see back-to-back cycles on the port
  property p_b2b;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    !GFX_FAST_WRITE_I |=> !GFX_BACK_TO_BACK_O;
  endproperty
  a_b2b: assert property (p_b2b)
    else $error("back to back allowed in 1x mode");

  property p_pmem;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    (CYC_VALID_I && !CYC_IO_I && !bctrl_r[gpb_pkg::BC_VGA])
      |=> CYC_TO_GFX_O == $past(mem_win);
  endproperty
  a_pmem: assert property (p_pmem)
    else $error("prefetch window routing wrong");

  property p_reserved;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    plimit_r[3:0] == 4'h0 && bctrl_r[7:4] == 4'h0 && !bctrl_r[1] &&
    errcmd_r[7:1] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

  property p_nores;
    @(posedge SYS_CLK_I) disable iff (RESET_I)
    !GFX_RESET_O;
  endproperty
  a_nores: assert property (p_nores)
    else $error("graphics reset driven");

  c_vga: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    CYC_VALID_I && CYC_IO_I && vga_io && bctrl_r[gpb_pkg::BC_VGA]);
  c_isa: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    CYC_VALID_I && CYC_IO_I && io_win && isa_hit);
  c_serr: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    SERR_MSG_O);
  c_irq: cover property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    IRQ_O);
endmodule // gpb_decode

// [gpb_pkg.sv]
/*
  gpb_pkg: register offsets, field positions, reset values and decode
  constants for the graphics port bridge decode and error control block.
  Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package gpb_pkg;
  // printed offsets are not all multiples of four: they are indices
  localparam logic [7:0]  IDX_PLIMIT   = 8'h26;
  localparam logic [7:0]  IDX_BCTRL    = 8'h3E;
  localparam logic [7:0]  IDX_ERRCMD   = 8'h40;
  localparam logic [7:0]  IDX_PBASE    = 8'h24;
  localparam logic [7:0]  IDX_IOWIN    = 8'h60;
  localparam logic [7:0]  IDX_CMD      = 8'h61;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'h62;
  localparam logic [7:0]  IDX_IRQ_EN   = 8'h63;
  localparam logic [7:0]  IDX_IRQ_CLR  = 8'h64;

  localparam logic [15:0] PLIMIT_RST   = 16'h0000;
  localparam logic [15:0] PBASE_RST    = 16'hFFF0;
  localparam logic [15:0] WIN_MASK     = 16'hFFF0;
  localparam logic [7:0]  BCTRL_RST    = 8'h00;
  localparam logic [7:0]  BCTRL_MASK   = 8'h0D;
  localparam logic [7:0]  ERRCMD_MASK  = 8'h01;

  localparam int BC_PER  = 0;
  localparam int BC_ISA  = 2;
  localparam int BC_VGA  = 3;
  localparam int BC_MAM  = 5;
  localparam int BC_SRST = 6;
  localparam int BC_FB2B = 7;
  localparam int EC_TAE  = 0;

  localparam logic [31:0] VGA_MEM_LO = 32'h000A0000;
  localparam logic [31:0] VGA_MEM_HI = 32'h000BFFFF;
  localparam logic [9:0]  VGA_IO1_LO = 10'h3B0;
  localparam logic [9:0]  VGA_IO1_HI = 10'h3BB;
  localparam logic [9:0]  VGA_IO2_LO = 10'h3C0;
  localparam logic [9:0]  VGA_IO2_HI = 10'h3DF;
  localparam logic [19:0] LIMIT_FILL = 20'hFFFFF;
  localparam logic [31:0] ALL_ONES   = 32'hFFFFFFFF;

  // interrupt status bits
  localparam int EV_PERR = 0;
  localparam int EV_TA   = 1;
  localparam int EV_MA   = 2;
  localparam int EV_SERR = 3;
endpackage

// [gpb_gfx_model.sv]
/*
  gpb_gfx_model: graphics controller on the port side. It ends master
  transfers at once or after three idle cycles, with an abort on command.
  Assumes the bench pulses go_i for one cycle per transfer.
*/
`timescale 1ns/1ns
module gpb_gfx_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic        abort_i,
  input  wire logic        slow_i,
  input  wire logic [31:0] data_i,
  output logic             valid_o,
  output logic             write_o,
  output logic             abort_o,
  output logic      [31:0] rdata_o
);
  logic        busy_r;
  logic [1:0]  wait_r;
  logic [31:0] data_r;

  always_ff @(posedge clk_i) begin
    valid_o <= 1'b0;
    if (rst_i) begin
      busy_r  <= 1'b0;
      rdata_o <= 32'h0;
    end else if (go_i) begin
      busy_r  <= 1'b1;
      wait_r  <= slow_i ? 2'h3 : 2'h0;
      write_o <= wr_i;
      abort_o <= abort_i;
      data_r  <= data_i;
    end else if (busy_r && wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else if (busy_r) begin
      valid_o <= 1'b1;
      busy_r  <= 1'b0;
      rdata_o <= write_o ? ~data_r : data_r;
    end else begin
      // released data lines keep moving so a stale value never passes
      rdata_o <= ~rdata_o;
    end
  end
endmodule // gpb_gfx_model

// [testbench.sv]
/*
  testbench: self-checking bench for gpb_decode over AHB-Lite, host
  cycles and port events. Assumes gpb_gfx_model ends master transfers.
*/
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        cv = 1'b0, cio = 1'b0, fw = 1'b0, pe = 1'b0, ta = 1'b0;
  logic        go = 1'b0, mwr = 1'b0, mab = 1'b0, slow = 1'b0;
  logic [31:0] caddr = 32'h0, mdat = 32'h0, mai, mao;
  logic        done, togfx, b2b, grst, mav, maw, maa, mad, serr, irq;
  int          err_count = 0, checked = 0, cyc = 0;

  initial forever #20 clk = ~clk;

  gpb_decode dut (
    .SYS_CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .CYC_VALID_I(cv),
    .CYC_IO_I(cio), .CYC_ADDR_I(caddr), .CYC_DONE_O(done),
    .CYC_TO_GFX_O(togfx), .GFX_FAST_WRITE_I(fw),
    .GFX_BACK_TO_BACK_O(b2b), .GFX_RESET_O(grst), .MA_VALID_I(mav),
    .MA_WRITE_I(maw), .MA_RDATA_I(mai), .MA_ABORT_I(maa),
    .MA_DONE_O(mad), .MA_RDATA_O(mao), .GFX_PARITY_ERR_I(pe),
    .GFX_TARGET_ABORT_I(ta), .SERR_MSG_O(serr), .IRQ_O(irq));

  gpb_gfx_model gfx (
    .clk_i(clk), .rst_i(rst), .go_i(go), .wr_i(mwr), .abort_i(mab),
    .slow_i(slow), .data_i(mdat), .valid_o(mav), .write_o(maw),
    .abort_o(maa), .rdata_o(mai));

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // byte address is four times the register index
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] i,
                     input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic route(input logic io, input logic [31:0] a, input logic e);
    @(posedge clk);
    cv <= 1'b1;
    cio <= io;
    caddr <= a;
    @(posedge clk);
    cv <= 1'b0;
    repeat (3) if (done !== 1'b1) @(posedge clk);
    chk("cyc_done", {31'h0, done}, 32'h1);
    chk("route", {31'h0, togfx}, {31'h0, e});
  endtask

  task automatic t_regs;
    rdc("plimit", gpb_pkg::IDX_PLIMIT, 32'h0);
    rdc("pbase", gpb_pkg::IDX_PBASE, 32'h0000FFF0);
    rdc("bctrl", gpb_pkg::IDX_BCTRL, 32'h0);
    rdc("errcmd", gpb_pkg::IDX_ERRCMD, 32'h0);
    wr(gpb_pkg::IDX_PLIMIT, 32'hFFFFFFFF);
    rdc("plimit", gpb_pkg::IDX_PLIMIT, 32'h0000FFF0);
    wr(gpb_pkg::IDX_BCTRL, 32'hFFFFFFFF);
    rdc("bctrl", gpb_pkg::IDX_BCTRL, 32'h0000000D);
    wr(gpb_pkg::IDX_ERRCMD, 32'hFFFFFFFF);
    rdc("errcmd", gpb_pkg::IDX_ERRCMD, 32'h00000001);
    wr(8'h10, 32'hFFFFFFFF);
    rdc("unmapped", 8'h10, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("gfx_reset", {31'h0, grst}, 32'h0);
    wr(gpb_pkg::IDX_BCTRL, 32'h0);
    wr(gpb_pkg::IDX_ERRCMD, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_pref;
    wr(gpb_pkg::IDX_PBASE, 32'h00001230);
    wr(gpb_pkg::IDX_PLIMIT, 32'h00001250);
    route(1'b0, 32'h122FFFFF, 1'b0);
    route(1'b0, 32'h12300000, 1'b1);
    route(1'b0, 32'h125FFFFF, 1'b1);
    route(1'b0, 32'h12600000, 1'b0);
    $display("t_pref done");
  endtask

  task automatic t_isa;
    wr(gpb_pkg::IDX_IOWIN, 32'h1FFF1000);
    route(1'b1, 32'h00001000, 1'b1);
    route(1'b1, 32'h00001300, 1'b1);
    route(1'b1, 32'h00002000, 1'b0);
    wr(gpb_pkg::IDX_BCTRL, 32'h00000004);
    route(1'b1, 32'h000010FF, 1'b1);
    route(1'b1, 32'h00001100, 1'b0);
    route(1'b1, 32'h00001BFF, 1'b0);
    route(1'b1, 32'h00001C00, 1'b1);
    route(1'b1, 32'h00000100, 1'b0);
    route(1'b0, 32'h12340100, 1'b1);
    $display("t_isa done");
  endtask

  task automatic t_vga;
    wr(gpb_pkg::IDX_BCTRL, 32'h0);
    route(1'b0, 32'h000A0000, 1'b0);
    route(1'b1, 32'h000003C0, 1'b0);
    wr(gpb_pkg::IDX_PBASE, 32'h0);
    wr(gpb_pkg::IDX_PLIMIT, 32'h0);
    route(1'b0, 32'h000A0000, 1'b1);
    wr(gpb_pkg::IDX_PBASE, 32'h0000FFF0);
    wr(gpb_pkg::IDX_BCTRL, 32'h0000000C);
    route(1'b0, 32'h000A0000, 1'b1);
    route(1'b0, 32'h000BFFFF, 1'b1);
    route(1'b0, 32'h000C0000, 1'b0);
    route(1'b0, 32'h0009FFFF, 1'b0);
    route(1'b1, 32'h000003B0, 1'b1);
    route(1'b1, 32'h000013C0, 1'b1);
    route(1'b1, 32'h000003BB, 1'b1);
    route(1'b1, 32'h000003BC, 1'b0);
    route(1'b1, 32'h000003DF, 1'b1);
    route(1'b1, 32'h000003E0, 1'b0);
    route(1'b1, 32'h0000FFC5, 1'b1);
    route(1'b1, 32'h000083AF, 1'b0);
    wr(gpb_pkg::IDX_BCTRL, 32'h0);
    $display("t_vga done");
  endtask

  task automatic ma(input logic w, a, s, input logic [31:0] d, e);
    @(posedge clk);
    go <= 1'b1;
    mwr <= w;
    mab <= a;
    slow <= s;
    mdat <= d;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) if (mad !== 1'b1) @(posedge clk);
    chk("ma_done", {31'h0, mad}, 32'h1);
    chk("ma_rdata", mao, e);
  endtask

  task automatic t_master;
    ma(1'b0, 1'b0, 1'b0, 32'h12345678, 32'h12345678);
    ma(1'b0, 1'b1, 1'b1, 32'h12345678, 32'hFFFFFFFF);
    ma(1'b0, 1'b0, 1'b1, 32'h0000AAAA, 32'h0000AAAA);
    ma(1'b1, 1'b1, 1'b0, 32'h55555555, 32'h0000AAAA);
    @(posedge clk);
    fw <= 1'b1;
    repeat (2) @(posedge clk);
    chk("back_to_back", {31'h0, b2b}, 32'h1);
    fw <= 1'b0;
    repeat (2) @(posedge clk);
    chk("back_to_back", {31'h0, b2b}, 32'h0);
    $display("t_master done");
  endtask

  task automatic ev(input logic par, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    pe <= par;
    ta <= !par;
    @(posedge clk);
    pe <= 1'b0;
    ta <= 1'b0;
    repeat (3) begin
      @(posedge clk);
      seen = seen | serr;
    end
    chk("serr_msg", {31'h0, seen}, {31'h0, e});
  endtask

  task automatic t_err;
    rdc("irq_status", gpb_pkg::IDX_IRQ_STAT, 32'h00000004);
    wr(gpb_pkg::IDX_IRQ_CLR, 32'h0000000F);
    wr(gpb_pkg::IDX_IRQ_EN, 32'h0);
    wr(gpb_pkg::IDX_CMD, 32'h00000001);
    wr(gpb_pkg::IDX_ERRCMD, 32'h00000001);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b1);
    wr(gpb_pkg::IDX_BCTRL, 32'h00000001);
    ev(1'b1, 1'b1);
    wr(gpb_pkg::IDX_CMD, 32'h0);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b0);
    wr(gpb_pkg::IDX_CMD, 32'h00000001);
    wr(gpb_pkg::IDX_ERRCMD, 32'h0);
    ev(1'b0, 1'b0);
    rdc("irq_status", gpb_pkg::IDX_IRQ_STAT, 32'h0000000B);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(gpb_pkg::IDX_IRQ_EN, 32'h00000002);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(gpb_pkg::IDX_IRQ_CLR, 32'h00000002);
    repeat (2) @(posedge clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    rdc("irq_status", gpb_pkg::IDX_IRQ_STAT, 32'h00000009);
    rdc("irq_clear", gpb_pkg::IDX_IRQ_CLR, 32'h0);
    $display("t_err done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pref();
    t_isa();
    t_vga();
    t_master();
    t_err();
    conclude();
  end
endmodule // testbench
